// *** bench/gps_mgmt_model.sv ***
// management controller model: issues one-cycle register strobes
`timescale 1ns/1ps
module gps_mgmt_model
  import gps_pkg::*;
(
  input  wire logic           clock,
  output gps_pkg::gps_req_t   req
);
  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    req = '0;
  end

  // ----------------------------------------------------------------
  // one access per call; a gap cycle follows so strobes never re-arm
  // in the same time step that lowered them
  // ----------------------------------------------------------------
  task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
    @(posedge clock);
    #1;
    req.addr  = a;
    req.wdata = d;
    req.wr    = w;
    req.rd    = ~w;
    @(posedge clock);
    #1;
    req.rd    = 1'b0;
    req.wr    = 1'b0;
    // released fields are scrambled so nothing leans on stale values
    req.addr  = ~a;
    req.wdata = ~d;
  endtask

  // data word first, then the write-direction control word
  task automatic ext_store(input logic [8:0] idx, input logic [15:0] d);
    access(ADDR_EXT_WRITE_DATA, 1'b1, d);
    access(ADDR_EXT_ACCESS_CONTROL, 1'b1, {7'h40, idx});
  endtask
endmodule

// *** bench/test_gps_regs.sv ***
// testbench: register map, status latches, idle counter, extended window
`timescale 1ns/1ps
module test_gps_regs;
  import gps_pkg::*;
  logic              clock;
  logic              srst;
  gps_req_t          req;
  gps_stat_t         stat;
  logic       [15:0] reg_rdata;
  logic              reg_rvalid;
  logic              symbol_en;
  logic       [15:0] exp_q[$];    // expected read words, oldest first
  int                fail_count;
  int                n_checks;
  int                cycles;
  int                sym_gap;     // edges since the last symbol pulse
  logic        [4:0] r;           // live status bits 14:10
  logic        [8:0] idx_tab[8];
  logic       [15:0] dat_tab[8];
  logic       [15:0] v;
  logic        [5:0] base;

  gps_regs gps_regs_inst (
    .clock      (clock),
    .srst       (srst),
    .req        (req),
    .stat       (stat),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .symbol_en  (symbol_en)
  );
  gps_mgmt_model gps_mgmt_model_inst (
    .clock (clock),
    .req   (req)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_sym(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    gps_mgmt_model_inst.access(a, 1'b0, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    gps_mgmt_model_inst.access(a, 1'b1, d);
  endtask
  task automatic conclude();
    if (fail_count == 0 && n_checks > 0 && exp_q.size() == 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // result watcher: every read answer takes the oldest expectation
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() > 0) begin
        cmp16(reg_rdata, exp_q.pop_front());
      end else begin
        cmp16(reg_rdata, 16'hXXXX); // unexpected answer mismatches unless it reads all X
      end
    end
  end

  // ----------------------------------------------------------------
  // symbol enable: one pulse per symbol period, the first one two
  // edges after reset is released
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      sym_gap <= 0;
    end else begin
      cmp_sym(symbol_en, sym_gap == int'(SYMBOL_CYCLES));
      sym_gap <= (sym_gap == int'(SYMBOL_CYCLES)) ? 1 : sym_gap + 1;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    stat = '0;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(32'h9D88E23E));
    repeat (5) @(posedge clock);
    #1;
    srst = 1'b0;
    // reset values and fixed words, unmapped read answers zero
    rd_chk(ADDR_GIG_LINK_STATUS, 16'h0000);
    rd_chk(ADDR_EXT_ACCESS_CONTROL, 16'h0000);
    rd_chk(ADDR_EXT_WRITE_DATA, 16'h0000);
    rd_chk(ADDR_EXT_READ_DATA, 16'h0000);
    rd_chk(ADDR_EXT_CAP_STATUS, 16'h3000);
    rd_chk(5'h01, 16'h0000);
    // live status levels
    for (int i = 0; i < 6; i++) begin
      r = 5'($urandom);
      {stat.ms_resolved_master, stat.local_rcvr_ok, stat.remote_rcvr_ok,
       stat.partner_gig_full_duplex_able, stat.partner_gig_half_duplex_able} = r;
      rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 10'h000});
    end
    // fault pulse latches until read, then clears
    stat.ms_fault_event = 1'b1;
    @(posedge clock);
    #1;
    stat.ms_fault_event = 1'b0;
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b1, r, 10'h000});
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 10'h000});
    // a fault still present in the reading cycle wins over the clear
    stat.ms_fault_event = 1'b1;
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b1, r, 10'h000});
    stat.ms_fault_event = 1'b0;
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b1, r, 10'h000});
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 10'h000});
    // idle errors: 20 cycles is 10 symbols; one missing qualifier blocks counting
    for (int k = 0; k < 4; k++) begin
      {stat.receiving_idle, stat.transmit_mode_indication, stat.rx_error} =
        (k == 3) ? 3'b111 : (3'b111 ^ (3'b001 << k));
      repeat (20) @(posedge clock);
      #1;
      stat.rx_error = 1'b0;
      rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 2'b00, (k == 3) ? 8'h0A : 8'h00});
    end
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 10'h000});
    // reads land on symbol edges: an error counted in the clearing cycle stays as one
    @(posedge clock iff symbol_en === 1'b1);
    #1;
    stat.rx_error = 1'b1;
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 10'h000});
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 2'b00, 8'h01});
    stat.rx_error = 1'b0;
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 2'b00, 8'h01});
    // long error burst holds at the top of the count
    stat.rx_error = 1'b1;
    repeat (600) @(posedge clock);
    #1;
    stat.rx_error = 1'b0;
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 2'b00, 8'hFF});
    // read/write words; writes to read-only and unmapped places are ignored
    v = {1'b1, 15'($urandom)};
    wr(ADDR_EXT_ACCESS_CONTROL, v);
    rd_chk(ADDR_EXT_ACCESS_CONTROL, v);
    v = 16'($urandom);
    wr(ADDR_EXT_WRITE_DATA, v);
    rd_chk(ADDR_EXT_WRITE_DATA, v);
    wr(ADDR_EXT_CAP_STATUS, 16'hFFFF);
    wr(ADDR_EXT_READ_DATA, 16'hFFFF);
    wr(ADDR_GIG_LINK_STATUS, 16'hFFFF);
    wr(5'h1E, 16'hFFFF);
    rd_chk(ADDR_EXT_CAP_STATUS, 16'h3000);
    rd_chk(ADDR_EXT_READ_DATA, 16'h0000);
    rd_chk(ADDR_GIG_LINK_STATUS, {1'b0, r, 10'h000});
    rd_chk(5'h1E, 16'h0000);
    // extended store: pairs share an address on opposite pages
    base = 6'($urandom);
    for (int i = 0; i < 8; i++) begin
      idx_tab[i] = {i[0], base, i[2:1]};
      dat_tab[i] = 16'($urandom);
      gps_mgmt_model_inst.ext_store(idx_tab[i], dat_tab[i]);
    end
    for (int i = 7; i >= 0; i--) begin
      wr(ADDR_EXT_ACCESS_CONTROL, {7'h00, idx_tab[i]});
      rd_chk(ADDR_EXT_READ_DATA, dat_tab[i]);
      rd_chk(ADDR_EXT_ACCESS_CONTROL, {7'h00, idx_tab[i]});
    end
    repeat (5) @(posedge clock);
    conclude();
  end
endmodule

// *** rtl/gps_idle_err_cnt.sv ***
// module: saturating idle error counter, cleared by a status read
`timescale 1ns/1ps
module gps_idle_err_cnt (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       inc,
  input  wire logic       clr,
  output logic      [7:0] count
);
  import gps_pkg::*;

  logic [7:0] next_count; // counter next value

  // ----------------------------------------------------------------
  // next count: an increment in the clearing cycle is kept
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (clr) begin
      next_count = inc ? 8'h01 : 8'h00;
    end else if (inc && (count != IDLE_CNT_MAX)) begin
      next_count = 8'(count + 8'h01);
    end
  end

  // register stage only
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cnt_step;
    @(posedge clock) disable iff (srst)
      (inc && !clr && count != IDLE_CNT_MAX) |=> (count == 8'($past(count) + 8'h01));
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("idle count did not step");

  property p_cnt_clear;
    @(posedge clock) disable iff (srst)
      clr |=> (count == {7'h00, $past(inc)});
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("idle count not cleared");

  property p_cnt_hold;
    @(posedge clock) disable iff (srst)
      (!inc && !clr) |=> $stable(count);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("idle count moved alone");

endmodule

// *** rtl/gps_pkg.sv ***
// package: register map, field layout, reset values, timing and carriers of the status block
package gps_pkg;

  // ----------------------------------------------------------------
  // management register addresses (5-bit register number)
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_GIG_LINK_STATUS    = 5'h0A; // gigabit_link_status
  localparam logic [4:0]  ADDR_EXT_ACCESS_CONTROL = 5'h0B; // extended_access_control
  localparam logic [4:0]  ADDR_EXT_WRITE_DATA     = 5'h0C; // extended_write_data
  localparam logic [4:0]  ADDR_EXT_READ_DATA      = 5'h0D; // extended_read_data
  localparam logic [4:0]  ADDR_EXT_CAP_STATUS     = 5'h0F; // extended_capability_status

  // ----------------------------------------------------------------
  // gigabit_link_status field positions
  // ----------------------------------------------------------------
  localparam int          BIT_MS_FAULT            = 15;    // latch high, clear on read
  localparam int          BIT_MS_MASTER           = 14;    // resolved to master
  localparam int          BIT_LOCAL_RCVR_OK       = 13;    // local receiver ok
  localparam int          BIT_REMOTE_RCVR_OK      = 12;    // remote receiver ok
  localparam int          BIT_PARTNER_FD          = 11;    // partner gigabit full duplex
  localparam int          BIT_PARTNER_HD          = 10;    // partner gigabit half duplex
  localparam int          IDLE_CNT_W              = 8;     // idle error count width
  localparam logic [7:0]  IDLE_CNT_MAX            = 8'hFF; // count holds at this value

  // ----------------------------------------------------------------
  // extended_access_control field positions
  // ----------------------------------------------------------------
  localparam int          BIT_EXT_DIR_WRITE       = 15;    // 1 write, 0 read
  localparam int          BIT_EXT_PAGE            = 8;     // page select
  localparam int          EXT_ADDR_W              = 8;     // address field width
  localparam int          EXT_INDEX_W             = 9;     // page plus address
  localparam int          EXT_DEPTH               = 512;   // two pages of 256 words

  // ----------------------------------------------------------------
  // reset values and fixed words
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_EXT_CONTROL         = 16'h0000;
  localparam logic [15:0] RST_EXT_WRITE_DATA      = 16'h0000;
  localparam logic [15:0] RST_EXT_READ_DATA       = 16'h0000;
  localparam logic [15:0] RST_READ_RETURN         = 16'h0000;
  localparam logic [15:0] EXT_CAP_WORD            = 16'h3000; // base-x 00, base-t 11
  localparam logic [15:0] UNMAPPED_READ           = 16'h0000;

  // ----------------------------------------------------------------
  // timing: one gigabit symbol period derived from the core clock
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS           = 4;
  localparam int          SYMBOL_PERIOD_NS        = 8;
  localparam logic [1:0]  SYMBOL_CYCLES           = 2'(SYMBOL_PERIOD_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  addr;   // register number
    logic        rd;     // one-cycle read strobe
    logic        wr;     // one-cycle write strobe
    logic [15:0] wdata;  // write data
  } gps_req_t;

  typedef struct packed {
    logic ms_fault_event;               // pulse: master/slave config fault seen
    logic ms_resolved_master;           // level: 1 master, 0 slave
    logic local_rcvr_ok;                // level
    logic remote_rcvr_ok;               // level
    logic partner_gig_full_duplex_able; // level
    logic partner_gig_half_duplex_able; // level
    logic receiving_idle;               // level: receiver is receiving idles
    logic transmit_mode_indication;     // level: 1 means send-normal
    logic rx_error;                     // level: receive error status is error
  } gps_stat_t;

endpackage

// *** rtl/gps_regs.sv ***
// module: gigabit status, extended access window and capability registers
`timescale 1ns/1ps
module gps_regs (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire gps_pkg::gps_req_t req,
  input  wire gps_pkg::gps_stat_t stat,
  output logic            [15:0] reg_rdata,
  output logic                   reg_rvalid,
  output logic                   symbol_en
);
  import gps_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] ext_control;          // extended_access_control
  logic [15:0] ext_write_data;       // extended_write_data
  logic [15:0] ext_read_data;        // extended_read_data
  logic        ms_fault;             // latched fault flag
  logic [1:0]  sym_cnt;              // symbol divider
  logic        read_pending;         // array output waiting to be loaded
  logic [15:0] ext_mem_q;            // array read port
  // the store has no reset so that it can map onto a plain memory; software
  // must write a location before reading it back
  logic [15:0] ext_mem [EXT_DEPTH];  // extended register store, no reset
  logic [7:0]  idle_count;           // from the counter
  logic [15:0] status_word;          // assembled status
  logic [15:0] read_mux;             // selected read value

  logic [15:0] next_ext_control;
  logic [15:0] next_ext_write_data;
  logic [15:0] next_ext_read_data;
  logic        next_ms_fault;
  logic [1:0]  next_sym_cnt;
  logic        next_symbol_en;
  logic        next_read_pending;
  logic [15:0] next_reg_rdata;
  logic        next_reg_rvalid;

  // ----------------------------------------------------------------
  // decoded strobes
  // ----------------------------------------------------------------
  logic                   rd_status;   // read of gigabit_link_status
  logic                   wr_control;  // write of extended_access_control
  logic                   ext_wr_go;   // control write with write direction
  logic                   ext_rd_go;   // control write with read direction
  logic [EXT_INDEX_W-1:0] ext_index;   // page and address being written now
  logic                   idle_inc;    // qualified error symbol

  assign rd_status  = req.rd && (req.addr == ADDR_GIG_LINK_STATUS);
  assign wr_control = req.wr && (req.addr == ADDR_EXT_ACCESS_CONTROL);
  // the direction is taken from the word being written, not the old one
  assign ext_wr_go  = wr_control && req.wdata[BIT_EXT_DIR_WRITE];
  assign ext_rd_go  = wr_control && !req.wdata[BIT_EXT_DIR_WRITE];
  assign ext_index  = {req.wdata[BIT_EXT_PAGE], req.wdata[EXT_ADDR_W-1:0]};
  // only errors during idle reception in send-normal mode are counted
  assign idle_inc   = symbol_en && stat.receiving_idle
                      && stat.transmit_mode_indication && stat.rx_error;

  // ----------------------------------------------------------------
  // symbol period divider and control registers
  // ----------------------------------------------------------------
  always_comb begin
    // divider: one enable pulse per gigabit symbol
    next_sym_cnt   = (sym_cnt == SYMBOL_CYCLES - 2'd1) ? 2'd0 : 2'(sym_cnt + 2'd1);
    next_symbol_en = (sym_cnt == SYMBOL_CYCLES - 2'd1);
    // writable words, reserved control bits are kept as written
    next_ext_control    = ext_control;
    next_ext_write_data = ext_write_data;
    if (wr_control) begin
      next_ext_control = req.wdata;
    end
    if (req.wr && (req.addr == ADDR_EXT_WRITE_DATA)) begin
      next_ext_write_data = req.wdata;
    end
    // fault flag: a new fault in the read cycle wins over the clear
    next_ms_fault = stat.ms_fault_event || (ms_fault && !rd_status);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sym_cnt        <= 2'd0;
      symbol_en      <= 1'b0;
      ext_control    <= RST_EXT_CONTROL;
      ext_write_data <= RST_EXT_WRITE_DATA;
      ms_fault       <= 1'b0;
    end else begin
      sym_cnt        <= next_sym_cnt;
      symbol_en      <= next_symbol_en;
      ext_control    <= next_ext_control;
      ext_write_data <= next_ext_write_data;
      ms_fault       <= next_ms_fault;
    end
  end

  // ----------------------------------------------------------------
  // extended register store
  // ----------------------------------------------------------------
  // the write takes the data word already held, so software must load it first
  always_ff @(posedge clock) begin
    if (ext_wr_go) begin
      ext_mem[ext_index] <= ext_write_data;
    end
    if (ext_rd_go) begin
      ext_mem_q <= ext_mem[ext_index];
    end
  end

  // ----------------------------------------------------------------
  // read data word, loaded after a read-direction control write
  // ----------------------------------------------------------------
  always_comb begin
    next_read_pending  = ext_rd_go;
    next_ext_read_data = read_pending ? ext_mem_q : ext_read_data;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      read_pending  <= 1'b0;
      ext_read_data <= RST_EXT_READ_DATA;
    end else begin
      read_pending  <= next_read_pending;
      ext_read_data <= next_ext_read_data;
    end
  end

  // ----------------------------------------------------------------
  // idle error counter
  // ----------------------------------------------------------------
  gps_idle_err_cnt u_idle_cnt (
    .clock (clock),
    .srst  (srst),
    .inc   (idle_inc),
    .clr   (rd_status),
    .count (idle_count)
  );

  // ----------------------------------------------------------------
  // read return
  // ----------------------------------------------------------------
  always_comb begin
    status_word                     = 16'h0000;
    status_word[BIT_MS_FAULT]       = ms_fault;
    status_word[BIT_MS_MASTER]      = stat.ms_resolved_master;
    status_word[BIT_LOCAL_RCVR_OK]  = stat.local_rcvr_ok;
    status_word[BIT_REMOTE_RCVR_OK] = stat.remote_rcvr_ok;
    status_word[BIT_PARTNER_FD]     = stat.partner_gig_full_duplex_able;
    status_word[BIT_PARTNER_HD]     = stat.partner_gig_half_duplex_able;
    status_word[IDLE_CNT_W-1:0]     = idle_count;
    case (req.addr)
      ADDR_GIG_LINK_STATUS:    read_mux = status_word;
      ADDR_EXT_ACCESS_CONTROL: read_mux = ext_control;
      ADDR_EXT_WRITE_DATA:     read_mux = ext_write_data;
      ADDR_EXT_READ_DATA:      read_mux = ext_read_data;
      ADDR_EXT_CAP_STATUS:     read_mux = EXT_CAP_WORD;
      default:                 read_mux = UNMAPPED_READ;
    endcase
    // the returned word holds until the next read
    next_reg_rdata  = req.rd ? read_mux : reg_rdata;
    next_reg_rvalid = req.rd;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata  <= RST_READ_RETURN;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fault_sets;
    @(posedge clock) disable iff (srst)
      stat.ms_fault_event |=> ms_fault;
  endproperty
  a_fault_sets: assert property (p_fault_sets) else $error("fault flag not set");

  property p_fault_clears;
    @(posedge clock) disable iff (srst)
      (rd_status && !stat.ms_fault_event) |=> !ms_fault;
  endproperty
  a_fault_clears: assert property (p_fault_clears) else $error("fault not cleared");

  property p_fault_read;
    @(posedge clock) disable iff (srst)
      (rd_status && ms_fault) |=> reg_rvalid && reg_rdata[BIT_MS_FAULT];
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault not returned");

  property p_master_read;
    @(posedge clock) disable iff (srst)
      rd_status |=> reg_rdata[BIT_MS_MASTER] == $past(stat.ms_resolved_master);
  endproperty
  a_master_read: assert property (p_master_read) else $error("master bit wrong");

  property p_rcvr_read;
    @(posedge clock) disable iff (srst)
      rd_status |=> reg_rdata[BIT_LOCAL_RCVR_OK] == $past(stat.local_rcvr_ok)
                 && reg_rdata[BIT_REMOTE_RCVR_OK] == $past(stat.remote_rcvr_ok);
  endproperty
  a_rcvr_read: assert property (p_rcvr_read) else $error("receiver bits wrong");

  property p_partner_read;
    @(posedge clock) disable iff (srst)
      rd_status |=> reg_rdata[BIT_PARTNER_FD] == $past(stat.partner_gig_full_duplex_able)
                 && reg_rdata[BIT_PARTNER_HD] == $past(stat.partner_gig_half_duplex_able);
  endproperty
  a_partner_read: assert property (p_partner_read) else $error("partner bits wrong");

  property p_cap_read;
    @(posedge clock) disable iff (srst)
      (req.rd && req.addr == ADDR_EXT_CAP_STATUS) |=> reg_rdata[15:12] == 4'h3;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability bits wrong");

  property p_ctrl_store;
    @(posedge clock) disable iff (srst)
      wr_control |=> ext_control == $past(req.wdata);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control not stored");

  // store, one idle cycle, then a fetch of the same place: the fetched word
  // lands in the read data word two cycles after the fetch
  property p_ext_roundtrip;
    logic [15:0] d;
    @(posedge clock) disable iff (srst)
      (ext_wr_go, d = ext_write_data) ##1 !wr_control ##1 (ext_rd_go
        && ext_index == $past(ext_index, 2)) |-> ##2 (ext_read_data == d);
  endproperty
  a_ext_roundtrip: assert property (p_ext_roundtrip) else $error("bad readback");

  property p_symbol_rate;
    @(posedge clock) disable iff (srst)
      symbol_en |=> !symbol_en ##1 symbol_en;
  endproperty
  a_symbol_rate: assert property (p_symbol_rate) else $error("symbol enable rate wrong");

  // ----------------------------------------------------------------
  // latch, count, extended window and read answer checks
  // ----------------------------------------------------------------
  property p_fault_holds;
    @(posedge clock) disable iff (srst)
      (ms_fault && !rd_status) |=> ms_fault;
  endproperty
  a_fault_holds: assert property (p_fault_holds) else $error("fault dropped unread");

  property p_idle_read;
    @(posedge clock) disable iff (srst)
      rd_status |=> reg_rdata[IDLE_CNT_W-1:0] == $past(idle_count);
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("idle count not returned");

  property p_wdata_store;
    @(posedge clock) disable iff (srst)
      (req.wr && req.addr == ADDR_EXT_WRITE_DATA) |=> ext_write_data == $past(req.wdata);
  endproperty
  a_wdata_store: assert property (p_wdata_store) else $error("write data not stored");

  property p_ext_write;
    @(posedge clock) disable iff (srst)
      ext_wr_go |=> ext_mem[$past(ext_index)] == $past(ext_write_data);
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("store missed");

  property p_rdata_load;
    @(posedge clock) disable iff (srst)
      read_pending |=> ext_read_data == $past(ext_mem_q);
  endproperty
  a_rdata_load: assert property (p_rdata_load) else $error("read word not loaded");

  property p_rdata_hold;
    @(posedge clock) disable iff (srst)
      !read_pending |=> $stable(ext_read_data);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read word moved");

  property p_rd_answer;
    @(posedge clock) disable iff (srst)
      req.rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");

  property p_rvalid_quiet;
    @(posedge clock) disable iff (srst)
      !req.rd |=> !reg_rvalid;
  endproperty
  a_rvalid_quiet: assert property (p_rvalid_quiet) else $error("stray read answer");

endmodule
